// ---- test/legacy_nmi_system_control_tb.sv ----
// self-checking bench for the legacy nmi and system control block
`timescale 1ns/10ps
module legacy_nmi_system_control_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr_stb = 1'b0;
  logic io_rd_stb = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic refresh_en = 1'b0;
  logic [1:0] err_req = 2'h0;
  logic timer2_out, refresh_done, io_channel_check_n, board_error_n;
  logic [7:0] io_rdata, rd_d, d;
  logic io_rdata_valid, nmi, timer2_gate, speaker_pin, fast_cpu_reset, addr_bit20_mask_n;
  logic [6:0] rtc_index;
  logic rd_v, t2s;
  logic [3:0] ctrl = 4'h0;
  logic [1:0] lat = 2'h0;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'h3953;
  int ticks = 0;
  int n;
  legacy_nmi_system_control legacy_nmi_system_control_i (.ref_clk(ref_clk), .resetn(resetn),
    .io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata),
    .timer2_out(timer2_out), .refresh_done(refresh_done),
    .io_channel_check_n(io_channel_check_n), .board_error_n(board_error_n),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .rtc_index(rtc_index), .nmi(nmi),
    .timer2_gate(timer2_gate), .speaker_pin(speaker_pin), .fast_cpu_reset(fast_cpu_reset),
    .addr_bit20_mask_n(addr_bit20_mask_n));
  sideband_model sideband_model_i (.ref_clk(ref_clk), .resetn(resetn),
    .timer2_gate(timer2_gate), .refresh_en(refresh_en), .err_req(err_req),
    .timer2_out(timer2_out), .refresh_done(refresh_done),
    .io_channel_check_n(io_channel_check_n), .board_error_n(board_error_n));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (refresh_done === 1'b1) ticks++;
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr_stb <= 1'b1;
    @(posedge ref_clk);
    io_wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd_stb <= 1'b1;
    #1 t2s = timer2_out;
    @(posedge ref_clk);
    io_rd_stb <= 1'b0;
    #1 rd_d = io_rdata;
    rd_v = io_rdata_valid;
  endtask
  task automatic r61();
    rd(legacy_nmi_pkg::PORT_STATUS_CTRL);
    chk({7'h0, rd_v}, 8'h01);
    chk(rd_d, {lat[1], lat[0], t2s, ticks[0], ctrl});
  endtask
  task automatic nmi_is(input logic e);
    @(posedge ref_clk);
    #1 chk({7'h0, nmi}, {7'h0, e});
  endtask
  task automatic pulse_len();
    n = 0;
    while (fast_cpu_reset === 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk(n[7:0], {4'h0, legacy_nmi_pkg::FAST_RESET_CYCLES});
  endtask
  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    r61();
    rd(legacy_nmi_pkg::PORT_FAST_RESET);
    chk(rd_d, 8'h24);
    for (int i = 0; i < 3; i++) begin
      rd((i == 0) ? legacy_nmi_pkg::PORT_NMI_GATE : (i == 1) ? 16'h0060 : 16'h0093);
      chk({rd_v, rd_d[6:0]}, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(legacy_nmi_pkg::PORT_STATUS_CTRL, d);
      ctrl = d[3:0];
      chk({7'h0, timer2_gate}, {7'h0, d[0]});
      wr(16'h0161, ~d);
      r61();
      wr(legacy_nmi_pkg::PORT_NMI_GATE, d);
      chk({1'b0, rtc_index}, {1'b0, d[6:0]});
    end
    wr(legacy_nmi_pkg::PORT_NMI_GATE, 8'h00);
    for (int k = 1; k < 4; k++) begin
      wr(legacy_nmi_pkg::PORT_STATUS_CTRL, k[7:0]);
      ctrl = k[3:0];
      for (int i = 0; i < 12; i++) begin
        t2s = timer2_out;
        @(posedge ref_clk);
        #1 chk({7'h0, speaker_pin}, {7'h0, t2s & ctrl[1]});
      end
    end
    wr(legacy_nmi_pkg::PORT_STATUS_CTRL, 8'h00);
    ctrl = 4'h0;
    @(posedge ref_clk);
    refresh_en <= 1'b1;
    repeat (40) @(posedge ref_clk);
    refresh_en <= 1'b0;
    r61();
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      err_req[s] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      err_req[s] <= 1'b0;
      lat[s] = 1'b1;
      nmi_is(1'b1);
      repeat (4) @(posedge ref_clk);
      r61();
      wr(legacy_nmi_pkg::PORT_NMI_GATE, 8'h80);
      nmi_is(1'b0);
      wr(legacy_nmi_pkg::PORT_NMI_GATE, 8'h00);
      nmi_is(1'b1);
      d = (s == 0) ? 8'h08 : 8'h04;
      wr(legacy_nmi_pkg::PORT_STATUS_CTRL, d);
      ctrl = d[3:0];
      lat[s] = 1'b0;
      nmi_is(1'b0);
      err_req[s] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      err_req[s] <= 1'b0;
      r61();
      repeat (4) @(posedge ref_clk);
      wr(legacy_nmi_pkg::PORT_STATUS_CTRL, 8'h00);
      ctrl = 4'h0;
      repeat (4) @(posedge ref_clk);
      r61();
    end
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'h01);
    pulse_len();
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'h03);
    chk({6'h0, fast_cpu_reset, addr_bit20_mask_n}, 8'h01);
    rd(legacy_nmi_pkg::PORT_FAST_RESET);
    chk(rd_d, 8'h27);
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'h02);
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'h01);
    pulse_len();
    chk({7'h0, addr_bit20_mask_n}, 8'h00);
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'hD8);
    rd(legacy_nmi_pkg::PORT_FAST_RESET);
    chk(rd_d, 8'h24);
    wr(legacy_nmi_pkg::PORT_FAST_RESET, 8'h03);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    #1 chk({6'h0, fast_cpu_reset, addr_bit20_mask_n}, 8'h00);
    rd(legacy_nmi_pkg::PORT_FAST_RESET);
    chk(rd_d, 8'h24);
    end_sim();
  end
endmodule

// ---- test/sideband_model.sv ----
// model of the timer 2 output, refresh pulses and error pins
`timescale 1ns/10ps
module sideband_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic timer2_gate,
  input wire logic refresh_en,
  input wire logic [1:0] err_req,
  output logic timer2_out,
  output logic refresh_done,
  output logic io_channel_check_n,
  output logic board_error_n
);
  logic [2:0] t_r;
  logic [2:0] f_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      t_r <= 3'h0;
      f_r <= 3'h0;
    end else begin
      t_r <= t_r + {2'h0, timer2_gate};
      f_r <= f_r + 3'h1;
    end
  end
  // timer output only moves while gated on
  assign timer2_out = t_r[1];
  assign refresh_done = refresh_en & (f_r == 3'h7);
  assign io_channel_check_n = ~err_req[0];
  assign board_error_n = ~err_req[1];
endmodule

// ---- verilog/fast_reset_pulser.sv ----
// fixed-width fast cpu reset pulse generator with rearm on bit clear
`timescale 1ns/10ps
module fast_reset_pulser (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fire,
  input wire logic pulse_bit,
  output logic fast_cpu_reset
);

  legacy_nmi_pkg::pulse_state_t state_r;
  legacy_nmi_pkg::pulse_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic out_r;
  logic out_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    case (state_r)
      legacy_nmi_pkg::PULSE_IDLE: begin
        if (fire) begin
          state_nxt = legacy_nmi_pkg::PULSE_ACTIVE;
          cnt_nxt = legacy_nmi_pkg::FAST_RESET_CYCLES - 4'h1;
          out_nxt = 1'b1;
        end
      end
      legacy_nmi_pkg::PULSE_ACTIVE: begin
        if (cnt_r == 4'h0) begin
          state_nxt = legacy_nmi_pkg::PULSE_WAIT_CLEAR;
          out_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      legacy_nmi_pkg::PULSE_WAIT_CLEAR: begin
        // only a written zero lets the next pulse start;
        // a one written right after that zero fires at once
        if (!pulse_bit && fire) begin
          state_nxt = legacy_nmi_pkg::PULSE_ACTIVE;
          cnt_nxt = legacy_nmi_pkg::FAST_RESET_CYCLES - 4'h1;
          out_nxt = 1'b1;
        end else if (!pulse_bit) begin
          state_nxt = legacy_nmi_pkg::PULSE_IDLE;
        end
      end
      default: begin
        state_nxt = legacy_nmi_pkg::PULSE_IDLE;
        out_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= legacy_nmi_pkg::PULSE_IDLE;
      cnt_r <= 4'h0;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign fast_cpu_reset = out_r;

  a_pulse_width: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(out_r) |-> out_r [*8] ##1 !out_r)
    else $error("fast reset pulse width wrong");

  a_no_retrigger: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == legacy_nmi_pkg::PULSE_WAIT_CLEAR && pulse_bit) |=> !out_r)
    else $error("fast reset pulsed before bit cleared");

  c_pulse: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(out_r));

endmodule

// ---- verilog/legacy_nmi_pkg.sv ----
// constants and types shared by the legacy nmi and system control block
package legacy_nmi_pkg;

  // byte i/o port addresses
  localparam logic [15:0] PORT_STATUS_CTRL = 16'h0061;
  localparam logic [15:0] PORT_NMI_GATE = 16'h0070;
  localparam logic [15:0] PORT_FAST_RESET = 16'h0092;

  // status and control port fields
  localparam int SC_TIMER2_EN = 0;
  localparam int SC_SPEAKER_EN = 1;
  localparam int SC_BOARD_ERR_DIS = 2;
  localparam int SC_IOCHK_DIS = 3;
  localparam int SC_REFRESH_TOG = 4;
  localparam int SC_TIMER2_OUT = 5;
  localparam int SC_IOCHK_REQ = 6;
  localparam int SC_BOARD_ERR_REQ = 7;
  localparam logic [3:0] SC_CTRL_RESET = 4'h0;
  localparam logic [7:0] SC_RESET = 8'h00;

  // nmi gate and rtc index port fields
  localparam int NG_GATE = 7;
  localparam logic NG_GATE_RESET = 1'b0;
  localparam logic [6:0] NG_INDEX_RESET = 7'h00;

  // fast reset and address mask port fields
  localparam int FR_PULSE = 0;
  localparam int FR_ADDR_MASK = 1;
  localparam logic [7:0] FR_RESET = 8'h24;
  localparam logic [7:0] FR_FIXED_ONES = 8'h24;

  // fast cpu reset pulse length in ref_clk cycles
  localparam logic [3:0] FAST_RESET_CYCLES = 4'h8;

  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_ACTIVE,
    PULSE_WAIT_CLEAR
  } pulse_state_t;

endpackage

// ---- verilog/legacy_nmi_system_control.sv ----
// legacy nmi gate, status/control port and fast reset/address mask port
//
// What this block does
// - nmi_gate_rtc_index write-only, low seven bits set the rtc memory index.
// - nmi_gate_rtc_index bit 7 set blocks all nmi sources; clear lets them through.
// - port 61h bit 0 enables timer counter 2; register resets to 00h.
// - port 61h bit 1 clear holds speaker low, set makes it follow timer 2.
// - port 61h bit 2 clear enables board error; set disables and clears it.
// - port 61h bit 3 clear enables channel check nmi; set disables and clears.
// - port 61h bit 4 flips after every completed refresh cycle.
// - port 61h bit 5 reads the live timer counter 2 output.
// - port 61h bit 6 reads 1 while channel check requests nmi; bit 3 clears.
// - port 61h bit 7 reads 1 while board error requests nmi; bit 2 clears.
// - writing 1 to fast_reset_addr_mask bit 0 while it holds 0 pulses fast cpu reset.
// - fast_reset_addr_mask bit 1 drives the address bit 20 mask pin directly.
// - fast_reset_addr_mask reserved bits read fixed 00100100 pattern; resets to 24h.
`timescale 1ns/10ps
module legacy_nmi_system_control (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr_stb,
  input wire logic io_rd_stb,
  input wire logic [7:0] io_wdata,
  input wire logic timer2_out,
  input wire logic refresh_done,
  input wire logic io_channel_check_n,
  input wire logic board_error_n,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  output logic [6:0] rtc_index,
  output logic nmi,
  output logic timer2_gate,
  output logic speaker_pin,
  output logic fast_cpu_reset,
  output logic addr_bit20_mask_n
);

  // port decode
  logic hit_sc;
  logic hit_ng;
  logic hit_fr;
  logic wr_sc;
  logic wr_ng;
  logic wr_fr;

  assign hit_sc = (io_addr == legacy_nmi_pkg::PORT_STATUS_CTRL);
  assign hit_ng = (io_addr == legacy_nmi_pkg::PORT_NMI_GATE);
  assign hit_fr = (io_addr == legacy_nmi_pkg::PORT_FAST_RESET);
  assign wr_sc = io_wr_stb && hit_sc;
  assign wr_ng = io_wr_stb && hit_ng;
  assign wr_fr = io_wr_stb && hit_fr;

  // pin synchronisers: bit 0 channel check, bit 1 board error
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= {board_error_n, io_channel_check_n};
      sync2_r <= sync1_r;
    end
  end

  logic iochk_active;
  logic serr_active;

  assign iochk_active = !sync2_r[0];
  assign serr_active = !sync2_r[1];

  // control and status state
  logic gate_r;
  logic gate_nxt;
  logic [6:0] index_r;
  logic [6:0] index_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic refresh_tog_r;
  logic refresh_tog_nxt;
  logic iochk_lat_r;
  logic iochk_lat_nxt;
  logic serr_lat_r;
  logic serr_lat_nxt;
  logic fr_bit0_r;
  logic fr_bit0_nxt;
  logic mask_r;
  logic mask_nxt;
  logic nmi_r;
  logic nmi_nxt;
  logic speaker_r;
  logic speaker_nxt;

  always_comb begin
    gate_nxt = gate_r;
    index_nxt = index_r;
    ctrl_nxt = ctrl_r;
    fr_bit0_nxt = fr_bit0_r;
    mask_nxt = mask_r;
    if (wr_ng) begin
      gate_nxt = io_wdata[legacy_nmi_pkg::NG_GATE];
      index_nxt = io_wdata[6:0];
    end
    if (wr_sc) begin
      ctrl_nxt = io_wdata[3:0];
    end
    if (wr_fr) begin
      fr_bit0_nxt = io_wdata[legacy_nmi_pkg::FR_PULSE];
      mask_nxt = io_wdata[legacy_nmi_pkg::FR_ADDR_MASK];
    end
    refresh_tog_nxt = refresh_tog_r ^ refresh_done;
    // a disable bit both blocks the source and clears the latch;
    // while enabled, an arriving error always latches
    iochk_lat_nxt = (iochk_lat_r || iochk_active)
      && !ctrl_nxt[legacy_nmi_pkg::SC_IOCHK_DIS];
    serr_lat_nxt = (serr_lat_r || serr_active)
      && !ctrl_nxt[legacy_nmi_pkg::SC_BOARD_ERR_DIS];
    nmi_nxt = (iochk_lat_r || serr_lat_r) && !gate_r;
    speaker_nxt = ctrl_r[legacy_nmi_pkg::SC_SPEAKER_EN] && timer2_out;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gate_r <= legacy_nmi_pkg::NG_GATE_RESET;
      index_r <= legacy_nmi_pkg::NG_INDEX_RESET;
      ctrl_r <= legacy_nmi_pkg::SC_CTRL_RESET;
      refresh_tog_r <= 1'b0;
      iochk_lat_r <= 1'b0;
      serr_lat_r <= 1'b0;
      fr_bit0_r <= legacy_nmi_pkg::FR_RESET[legacy_nmi_pkg::FR_PULSE];
      mask_r <= legacy_nmi_pkg::FR_RESET[legacy_nmi_pkg::FR_ADDR_MASK];
      nmi_r <= 1'b0;
      speaker_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      index_r <= index_nxt;
      ctrl_r <= ctrl_nxt;
      refresh_tog_r <= refresh_tog_nxt;
      iochk_lat_r <= iochk_lat_nxt;
      serr_lat_r <= serr_lat_nxt;
      fr_bit0_r <= fr_bit0_nxt;
      mask_r <= mask_nxt;
      nmi_r <= nmi_nxt;
      speaker_r <= speaker_nxt;
    end
  end

  // read path, answered one cycle after the read strobe
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = 1'b0;
    if (io_rd_stb && hit_sc) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {serr_lat_r, iochk_lat_r, timer2_out, refresh_tog_r, ctrl_r};
    end else if (io_rd_stb && hit_fr) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = legacy_nmi_pkg::FR_FIXED_ONES | {6'h00, mask_r, fr_bit0_r};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  fast_reset_pulser u_pulser (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .fire(wr_fr && io_wdata[legacy_nmi_pkg::FR_PULSE]),
    .pulse_bit(fr_bit0_r),
    .fast_cpu_reset(fast_cpu_reset)
  );

  assign io_rdata = rdata_r;
  assign io_rdata_valid = rvalid_r;
  assign rtc_index = index_r;
  assign nmi = nmi_r;
  assign timer2_gate = ctrl_r[legacy_nmi_pkg::SC_TIMER2_EN];
  assign speaker_pin = speaker_r;
  assign addr_bit20_mask_n = mask_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_rtc_index_write: assert property (
    wr_ng |=> rtc_index == $past(io_wdata[6:0]))
    else $error("rtc index not loaded");

  a_nmi_gate_blocks: assert property (
    gate_r |=> !nmi)
    else $error("nmi passed while gated");

  a_nmi_from_latch: assert property (
    ((iochk_lat_r || serr_lat_r) && !gate_r) |=> nmi)
    else $error("nmi missing for latched error");

  a_timer2_gate_write: assert property (
    wr_sc |=> timer2_gate == $past(io_wdata[0]))
    else $error("timer 2 gate not written");

  a_speaker_low: assert property (
    !ctrl_r[legacy_nmi_pkg::SC_SPEAKER_EN] |=> !speaker_pin)
    else $error("speaker not held low");

  a_speaker_follow: assert property (
    ctrl_r[legacy_nmi_pkg::SC_SPEAKER_EN] |=> speaker_pin == $past(timer2_out))
    else $error("speaker not following timer 2");

  a_serr_clear: assert property (
    (wr_sc && io_wdata[legacy_nmi_pkg::SC_BOARD_ERR_DIS]) ##1 !wr_sc |-> !serr_lat_r [*2])
    else $error("board error not cleared");

  a_iochk_clear: assert property (
    (wr_sc && io_wdata[legacy_nmi_pkg::SC_IOCHK_DIS]) ##1 !wr_sc |-> !iochk_lat_r [*2])
    else $error("channel check not cleared");

  a_refresh_toggle: assert property (
    refresh_done |=> refresh_tog_r != $past(refresh_tog_r))
    else $error("refresh bit did not flip");

  a_timer2_readback: assert property (
    (io_rd_stb && hit_sc) |=> io_rdata_valid && io_rdata[5] == $past(timer2_out))
    else $error("timer 2 status wrong");

  a_iochk_latch: assert property (
    (iochk_active && !ctrl_r[legacy_nmi_pkg::SC_IOCHK_DIS] && !wr_sc) |=> iochk_lat_r)
    else $error("channel check not latched");

  a_serr_latch: assert property (
    (serr_active && !ctrl_r[legacy_nmi_pkg::SC_BOARD_ERR_DIS] && !wr_sc) |=> serr_lat_r)
    else $error("board error not latched");

  a_mask_pin_write: assert property (
    wr_fr |=> addr_bit20_mask_n == $past(io_wdata[1]))
    else $error("address mask pin not following bit 1");

  a_fixed_bits_read: assert property (
    (io_rd_stb && hit_fr) |=> io_rdata_valid
      && io_rdata[7:2] == legacy_nmi_pkg::FR_FIXED_ONES[7:2])
    else $error("fast_reset_addr_mask reserved bits wrong");

  a_reset_start: assert property (
    (wr_fr && io_wdata[0] && !fr_bit0_r && !fast_cpu_reset) |=> fast_cpu_reset)
    else $error("fast reset not started");

  a_index_hold: assert property (
    !wr_ng |=> $stable(rtc_index))
    else $error("rtc index changed without write");

  a_no_read_answer: assert property (
    (io_rd_stb && !hit_sc && !hit_fr) |=> !io_rdata_valid && io_rdata == 8'h00)
    else $error("unmapped or write-only port answered");

  a_ctrl_readback: assert property (
    (io_rd_stb && hit_sc) |=> io_rdata[3:0] == $past(ctrl_r)
      && io_rdata[4] == $past(refresh_tog_r))
    else $error("status port control bits wrong");

  a_latch_readback: assert property (
    (io_rd_stb && hit_sc) |=> io_rdata[7:6] == $past({serr_lat_r, iochk_lat_r}))
    else $error("status port error bits wrong");

  a_serr_blocked: assert property (
    (ctrl_r[legacy_nmi_pkg::SC_BOARD_ERR_DIS] && !wr_sc) |=> !serr_lat_r)
    else $error("board error latched while disabled");

  a_iochk_blocked: assert property (
    (ctrl_r[legacy_nmi_pkg::SC_IOCHK_DIS] && !wr_sc) |=> !iochk_lat_r)
    else $error("channel check latched while disabled");

  a_refresh_hold: assert property (
    !refresh_done |=> $stable(refresh_tog_r))
    else $error("refresh bit flipped without refresh");

  a_nmi_quiet: assert property (
    !(iochk_lat_r || serr_lat_r) |=> !nmi)
    else $error("nmi without latched error");

  a_mask_pin_hold: assert property (
    !wr_fr |=> $stable(addr_bit20_mask_n))
    else $error("address mask pin changed without write");

  a_low_bits_read: assert property (
    (io_rd_stb && hit_fr) |=> io_rdata[1:0] == $past({mask_r, fr_bit0_r}))
    else $error("fast_reset_addr_mask low bits wrong");

  c_nmi_raised: cover property ($rose(nmi));
  c_gate_blocks: cover property (gate_r && (iochk_lat_r || serr_lat_r));
  c_iochk_cleared: cover property (iochk_lat_r ##1 !iochk_lat_r);
  c_refresh_read: cover property (refresh_done ##1 (io_rd_stb && hit_sc));

endmodule
